// File: design/acs_ctrl.sv
/*
 * Conversion start control and status for the first converter.
 * Holds the control register, start-source selection, tracking
 * control, busy and done status and a small interrupt unit.
 * Assumes the converter core and timer three run on clk_sys; the
 * external strobe is asynchronous and is synchronised here.
 */
// Design decisions made here: the register addresses and the plain strobed port.
// Contract
// - Track mode 1: tracking follows start source
// - Done flag set when conversion finishes
// - Busy reads 1 during a conversion
// - Done flag sets as busy falls
// - Busy write 1 starts only with 00
// - Code 00 starts on software busy write
// - Code 01 starts on timer three overflow
// - Code 10 starts on strobe rising edge
// - Track mode 0: track unless converting
`timescale 1ns/1ns
module acs_ctrl (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire acs_pkg::acs_bus_req_s bus_req,
   output logic [31:0] rdata,
   input wire logic timer3_ovf,
   input wire logic ext_convert_strobe,
   input wire logic conv_end,
   output logic conv_start,
   output logic track_en,
   output logic irq
);
   import acs_pkg::*;

   // ==========================================================
   // Declarations
   logic ext_s1_q;
   logic ext_s2_q;
   logic ext_s3_q;
   logic ext_rise;
   logic tm_q;
   logic tm_d;
   logic [1:0] sel_q;
   logic [1:0] sel_d;
   logic done_q;
   logic done_d;
   logic [1:0] stat_q;
   logic [1:0] stat_d;
   logic [1:0] en_q;
   logic [1:0] en_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   acs_state_e state_q;
   acs_state_e state_d;
   logic [4:0] cnt_q;
   logic [4:0] cnt_d;
   logic start_q;
   logic start_d;
   logic track_q;
   logic track_d;
   logic busy;
   logic busy_fall;
   logic ctrl_wr;
   logic sw_start;
   logic hw_start;
   logic start_evt;
   logic drop_evt;

   // ==========================================================
   // Strobe pin synchroniser; the edge is taken past the second stage
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         ext_s1_q <= 1'b0;
         ext_s2_q <= 1'b0;
         ext_s3_q <= 1'b0;
      end else begin
         ext_s1_q <= ext_convert_strobe;
         ext_s2_q <= ext_s1_q;
         ext_s3_q <= ext_s2_q;
      end
   end

   assign ext_rise = ext_s2_q & ~ext_s3_q;

   // ==========================================================
   // Start event decode
   // Software start looks at the selector being written, so one write can
   // both pick code 00 and start.
   assign ctrl_wr = bus_req.wr && (bus_req.addr == ACS_OFF_CTRL);
   assign sw_start = ctrl_wr && bus_req.wdata[ACS_BUSY_BIT]
                     && (bus_req.wdata[ACS_SEL_HI:ACS_SEL_LO] == ACS_SEL_SW);
   // Code 11 has no hardware source and so never starts
   always_comb begin
      case (sel_q)
         ACS_SEL_TMR: hw_start = timer3_ovf;
         ACS_SEL_EXT: hw_start = ext_rise;
         default: hw_start = 1'b0;
      endcase
   end

   assign start_evt = sw_start | hw_start;
   assign busy = (state_q != ACS_ST_IDLE);
   // Starts that land on a running conversion are dropped, not queued
   assign drop_evt = start_evt & busy;
   assign busy_fall = (state_q == ACS_ST_CONV) && conv_end;

   // ==========================================================
   // Conversion sequencer: next state
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      start_d = 1'b0;
      case (state_q)
         ACS_ST_IDLE: begin
            if (start_evt) begin
               // A write that sets the track bit and starts in one go tracks first
               if (tm_d) begin
                  state_d = ACS_ST_TRACK;
                  cnt_d = ACS_TRACK_LOAD;
               end else begin
                  state_d = ACS_ST_CONV;
                  start_d = 1'b1;
               end
            end
         end
         ACS_ST_TRACK: begin
            // Tracking window opened by the start event
            if (cnt_q == 5'h00) begin
               state_d = ACS_ST_CONV;
               start_d = 1'b1;
            end else begin
               cnt_d = cnt_q - 5'h01;
            end
         end
         ACS_ST_CONV: begin
            if (conv_end) begin
               state_d = ACS_ST_IDLE;
            end
         end
         default: begin
            state_d = ACS_ST_IDLE;
         end
      endcase
      // Track mode 0 samples the input whenever idle
      track_d = tm_d ? (state_d == ACS_ST_TRACK) : (state_d == ACS_ST_IDLE);
   end

   // Conversion sequencer: registers
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         state_q <= ACS_ST_IDLE;
         cnt_q <= 5'h00;
         start_q <= 1'b0;
         track_q <= 1'b1;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         start_q <= start_d;
         track_q <= track_d;
      end
   end

   // ==========================================================
   // Control register and done flag: next values
   // A finish in the same cycle as a clearing write keeps the flag set.
   always_comb begin
      tm_d = tm_q;
      sel_d = sel_q;
      done_d = done_q;
      if (ctrl_wr) begin
         tm_d = bus_req.wdata[ACS_TM_BIT];
         sel_d = bus_req.wdata[ACS_SEL_HI:ACS_SEL_LO];
         if (!bus_req.wdata[ACS_DONE_BIT]) begin
            done_d = 1'b0;
         end
      end
      if (busy_fall) begin
         done_d = 1'b1;
      end
   end

   // Control register and done flag: registers
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         tm_q <= ACS_TM_RST;
         sel_q <= ACS_SEL_RST;
         done_q <= 1'b0;
      end else begin
         tm_q <= tm_d;
         sel_q <= sel_d;
         done_q <= done_d;
      end
   end

   // ==========================================================
   // Interrupt status, enable and clear: next values
   always_comb begin
      stat_d = stat_q;
      en_d = en_q;
      if (bus_req.wr && (bus_req.addr == ACS_OFF_CLR)) begin
         stat_d = stat_q & ~bus_req.wdata[ACS_INT_W-1:0];
      end
      if (bus_req.wr && (bus_req.addr == ACS_OFF_EN)) begin
         en_d = bus_req.wdata[ACS_INT_W-1:0];
      end
      // Events win over a clear in the same cycle
      if (busy_fall) begin
         stat_d[ACS_INT_DONE] = 1'b1;
      end
      if (drop_evt) begin
         stat_d[ACS_INT_DROP] = 1'b1;
      end
   end

   // Interrupt registers
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         stat_q <= ACS_INT_RST;
         en_q <= ACS_INT_RST;
      end else begin
         stat_q <= stat_d;
         en_q <= en_d;
      end
   end

   // ==========================================================
   // Read data, valid in the cycle after the read strobe only
   always_comb begin
      rdata_d = 32'h0000_0000;
      if (bus_req.rd) begin
         case (bus_req.addr)
            ACS_OFF_CTRL: begin
               rdata_d[ACS_TM_BIT] = tm_q;
               rdata_d[ACS_DONE_BIT] = done_q;
               rdata_d[ACS_BUSY_BIT] = busy;
               rdata_d[ACS_SEL_HI:ACS_SEL_LO] = sel_q;
            end
            ACS_OFF_STAT: rdata_d[ACS_INT_W-1:0] = stat_q;
            ACS_OFF_EN: rdata_d[ACS_INT_W-1:0] = en_q;
            default: rdata_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         rdata_q <= 32'h0000_0000;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // ==========================================================
   // Outputs
   assign rdata = rdata_q;
   assign conv_start = start_q;
   assign track_en = track_q;
   assign irq = |(stat_q & en_q);

   // ==========================================================
   // Assertions
   default clocking acs_cb @(posedge clk_sys);
   endclocking
   default disable iff (!rstn);

   sequence s_idle_tm1_start;
      (state_q == ACS_ST_IDLE) && tm_d && start_evt;
   endsequence

   sequence s_tracking;
      track_q && !conv_start [*8];
   endsequence

   property p_track_then_convert;
      s_idle_tm1_start |=> s_tracking ##[22:23] (conv_start && !track_q);
   endproperty

   track_window_a: assert property (p_track_then_convert)
      else $error("tracking window not followed by a conversion start");

   done_on_fall_a: assert property ($fell(busy) |-> done_q && stat_q[ACS_INT_DONE])
      else $error("done flag not set as busy fell");

   done_sticky_a: assert property (done_q && !(ctrl_wr && !bus_req.wdata[ACS_DONE_BIT])
      |=> done_q)
      else $error("done flag cleared without a software write");

   done_source_a: assert property ($rose(done_q) |-> $past(state_q == ACS_ST_CONV)
      && $past(conv_end))
      else $error("done flag rose without a finished conversion");

   sw_start_a: assert property ((state_q == ACS_ST_IDLE) && !tm_d && sw_start
      |=> busy && conv_start)
      else $error("software start did not begin a conversion");

   sw_refuse_a: assert property ((state_q == ACS_ST_IDLE) && ctrl_wr
      && (bus_req.wdata[ACS_SEL_HI:ACS_SEL_LO] != ACS_SEL_SW) && !hw_start |=> !busy)
      else $error("busy write started with a non-software source");

   timer_start_a: assert property ((state_q == ACS_ST_IDLE) && !tm_d
      && (sel_q == ACS_SEL_TMR) && timer3_ovf |=> conv_start ##1 busy)
      else $error("timer overflow did not start a conversion");

   ext_start_a: assert property ((state_q == ACS_ST_IDLE) && !tm_d
      && (sel_q == ACS_SEL_EXT) && $rose(ext_s2_q) |=> conv_start)
      else $error("strobe edge did not start a conversion");

   code_none_a: assert property ((sel_q == ACS_SEL_NONE) && !ctrl_wr |-> !start_evt)
      else $error("selector code 11 produced a start");

   busy_ignore_a: assert property ((state_q == ACS_ST_CONV) && start_evt && !conv_end
      |=> (state_q == ACS_ST_CONV) && !conv_start)
      else $error("start while busy disturbed the conversion");

   track_cont_a: assert property (!tm_q && !busy |-> track_en)
      else $error("tracking stopped while idle in track mode 0");

   busy_read_a: assert property (bus_req.rd && (bus_req.addr == ACS_OFF_CTRL)
      |=> rdata[ACS_BUSY_BIT] == $past(busy))
      else $error("busy bit read back wrong");
endmodule

// File: design/acs_pkg.sv
/*
 * Shared constants and types of the conversion start control block:
 * register offsets, field positions, reset values, start-source codes,
 * tracking time and the bus carrier struct.
 * Assumes a single 10 MHz system clock.
 */
package acs_pkg;
   // ==========================================================
   // Register map (byte addresses)
   localparam logic [3:0] ACS_OFF_CTRL = 4'h0;
   localparam logic [3:0] ACS_OFF_STAT = 4'h4;
   localparam logic [3:0] ACS_OFF_CLR = 4'h8;
   localparam logic [3:0] ACS_OFF_EN = 4'hC;
   // ==========================================================
   // Control register fields
   localparam int ACS_TM_BIT = 6;
   localparam int ACS_DONE_BIT = 5;
   localparam int ACS_BUSY_BIT = 4;
   localparam int ACS_SEL_HI = 3;
   localparam int ACS_SEL_LO = 2;
   localparam logic [1:0] ACS_SEL_SW = 2'h0;
   localparam logic [1:0] ACS_SEL_TMR = 2'h1;
   localparam logic [1:0] ACS_SEL_EXT = 2'h2;
   localparam logic [1:0] ACS_SEL_NONE = 2'h3;
   localparam logic ACS_TM_RST = 1'h0;
   localparam logic [1:0] ACS_SEL_RST = 2'h0;
   // ==========================================================
   // Interrupt status, clear and enable layout
   localparam int ACS_INT_W = 2;
   localparam int ACS_INT_DONE = 0;
   localparam int ACS_INT_DROP = 1;
   localparam logic [1:0] ACS_INT_RST = 2'h0;
   // ==========================================================
   // Tracking window used when tracking follows the start source
   localparam int ACS_CLK_PERIOD_NS = 100;
   localparam int ACS_TRACK_TIME_NS = 3000;
   localparam int ACS_TRACK_CYC = (ACS_TRACK_TIME_NS + ACS_CLK_PERIOD_NS - 1)
                                  / ACS_CLK_PERIOD_NS;
   localparam logic [4:0] ACS_TRACK_LOAD = 5'(ACS_TRACK_CYC - 1);
   // ==========================================================
   // Types
   typedef struct packed {
      logic [3:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } acs_bus_req_s;
   typedef enum {ACS_ST_IDLE, ACS_ST_TRACK, ACS_ST_CONV} acs_state_e;
endpackage

// File: tb/acs_core_model.sv
/*
 * Behavioural converter core that faces the start control block.
 * Assumes conv_start is a one-cycle pulse on clk_sys.
 */
`timescale 1ns/1ns
module acs_core_model (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic conv_start,
   input wire logic slow,
   output logic conv_end,
   output int conv_cnt
);
   int left_q;
   // ==========================================================
   // Conversion timing
   // End pulse a fixed time after each start; slow mode keeps busy long enough
   // for a second start to arrive mid-conversion
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         left_q <= 0;
         conv_end <= 1'b0;
         conv_cnt <= 0;
      end else begin
         conv_end <= 1'b0;
         if (conv_start) begin
            left_q <= slow ? 20 : 3;
            conv_cnt <= conv_cnt + 1;
         end else if (left_q == 1) begin
            conv_end <= 1'b1;
            left_q <= 0;
         end else if (left_q > 1) begin
            left_q <= left_q - 1;
         end
      end
   end
endmodule

// File: tb/acs_ctrl_bench.sv
/*
 * Self-checking bench of the conversion start control block.
 * Assumes the converter core model answers every start pulse.
 */
`timescale 1ns/1ns
`define CHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin error_cnt++; \
$display("[ERR] %s exp %h got %h", nm, ex, gt); end end
module acs_ctrl_bench;
   import acs_pkg::*;
   logic clk_sys = 1'b0;
   logic rstn = 1'b0;
   acs_bus_req_s bus_req = '0;
   logic [31:0] rdata;
   logic timer3_ovf = 1'b0;
   logic ext_convert_strobe = 1'b0;
   logic slow = 1'b0;
   logic conv_end, conv_start, track_en, irq;
   int conv_cnt, error_cnt = 0, compares = 0, n, c0;
   // ==========================================================
   // Clock, design and partner
   initial begin
      forever #50 clk_sys = ~clk_sys;
   end
   acs_ctrl dut (.clk_sys(clk_sys), .rstn(rstn), .bus_req(bus_req), .rdata(rdata),
      .timer3_ovf(timer3_ovf), .ext_convert_strobe(ext_convert_strobe),
      .conv_end(conv_end), .conv_start(conv_start), .track_en(track_en), .irq(irq));
   acs_core_model core (.clk_sys(clk_sys), .rstn(rstn), .conv_start(conv_start),
      .slow(slow), .conv_end(conv_end), .conv_cnt(conv_cnt));
   // ==========================================================
   // Bus cycles and helpers
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      bus_req.addr <= a;
      bus_req.wdata <= d;
      bus_req.wr <= 1'b1;
      @(posedge clk_sys);
      bus_req.wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] ex, input string nm);
      @(posedge clk_sys);
      bus_req.addr <= a;
      bus_req.rd <= 1'b1;
      @(posedge clk_sys);
      bus_req.rd <= 1'b0;
      #1 `CHK(nm, ex, rdata)
   endtask
   task automatic pulse_tmr();
      @(posedge clk_sys);
      timer3_ovf <= 1'b1;
      @(posedge clk_sys);
      timer3_ovf <= 1'b0;
   endtask
   // Cycles until the start pulse, the cycle after the calling edge being 1;
   // bounded so a missing start cannot hang
   task automatic wait_start();
      n = 1;
      #1;
      while (conv_start !== 1'b1 && n < 60) begin
         @(posedge clk_sys);
         #1 n++;
      end
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_reset();
      rd(ACS_OFF_CTRL, 32'h0, "ctrl reset");
      `CHK("track idle", 1'b1, track_en)
      `CHK("irq reset", 1'b0, irq)
   endtask
   task automatic t_sw();
      wr(ACS_OFF_EN, 32'h3);
      wr(ACS_OFF_CTRL, 32'h10);
      wait_start();
      `CHK("sw start", 1, n)
      `CHK("no track in conv", 1'b0, track_en)
      rd(ACS_OFF_CTRL, 32'h10, "busy");
      repeat (6) @(posedge clk_sys);
      rd(ACS_OFF_CTRL, 32'h20, "done");
      rd(ACS_OFF_STAT, 32'h1, "stat done");
      rd(ACS_OFF_EN, 32'h3, "enable");
      `CHK("irq on", 1'b1, irq)
      rd(ACS_OFF_CTRL, 32'h20, "done sticky");
      wr(ACS_OFF_CLR, 32'h1);
      #1 `CHK("irq off", 1'b0, irq)
      wr(ACS_OFF_CTRL, 32'h0);
      rd(ACS_OFF_CTRL, 32'h0, "done cleared");
   endtask
   // Busy write 0, busy write with sel 01 and code 11 sources must not start
   task automatic t_refuse();
      c0 = conv_cnt;
      wr(ACS_OFF_CTRL, 32'h14);
      wr(ACS_OFF_CTRL, 32'h0C);
      pulse_tmr();
      ext_convert_strobe <= 1'b1;
      wr(ACS_OFF_CTRL, 32'h1C);
      repeat (8) @(posedge clk_sys);
      ext_convert_strobe <= 1'b0;
      `CHK("no start", c0, conv_cnt)
   endtask
   task automatic t_timer();
      slow <= 1'b1;
      wr(ACS_OFF_CTRL, 32'h04);
      c0 = conv_cnt;
      pulse_tmr();
      wait_start();
      `CHK("tmr start", 1, n)
      pulse_tmr();
      repeat (25) @(posedge clk_sys);
      `CHK("drop busy", c0 + 1, conv_cnt)
      rd(ACS_OFF_STAT, 32'h3, "stat drop");
      wr(ACS_OFF_CLR, 32'h3);
      slow <= 1'b0;
   endtask
   task automatic t_ext();
      wr(ACS_OFF_CTRL, 32'h08);
      @(posedge clk_sys);
      ext_convert_strobe <= 1'b1;
      wait_start();
      // Pin edge is taken at the third clock edge after it rises
      `CHK("ext start", 4, n)
      @(posedge clk_sys);
      ext_convert_strobe <= 1'b0;
      repeat (8) @(posedge clk_sys);
   endtask
   // Track mode 1: 30 cycles of tracking, then the start pulse
   task automatic t_track();
      wr(ACS_OFF_CTRL, 32'h50);
      @(posedge clk_sys);
      #1 `CHK("track on", 1'b1, track_en)
      wait_start();
      `CHK("track time", 30, n)
      `CHK("track off", 1'b0, track_en)
      repeat (8) @(posedge clk_sys);
   endtask
   // ==========================================================
   // Verdict
   task automatic tally_and_finish();
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Watchdog: the tests need about 140 cycles
   initial begin
      repeat (3000) @(posedge clk_sys);
      error_cnt++;
      tally_and_finish();
   end
   initial begin
      repeat (3) @(posedge clk_sys);
      rstn <= 1'b1;
      t_reset();
      t_sw();
      t_refuse();
      t_timer();
      t_ext();
      t_track();
      tally_and_finish();
   end
endmodule
